// >>> verilog/disp_pkg.sv
// Shared constants and types for the memory-side integrity and strobe pin logic.
`default_nettype none
package disp_pkg;
    localparam int CLK_PERIOD_PS = 20000;
    localparam int CRC_PULSE_NS = 120;
    localparam int CRC_PULSE_CYC = (CRC_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PAR_RECOV_NS = 2000;
    localparam int PAR_RECOV_CYC = (PAR_RECOV_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RD_BEAT_NS = 40;
    localparam int RD_BEAT_CYC = (RD_BEAT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int BURST_BEATS = 8;
    localparam int CHOP_BEATS = 4;
    localparam int SH_MASK_POS = 0;
    localparam int SH_WDBI_POS = 1;
    localparam int SH_RDBI_POS = 2;
    localparam int AUTO_PRECHARGE_BIT_POS = 10;
    localparam int BURST_CHOP_BIT_POS = 12;
    localparam int A14_POS = 14;
    localparam int A15_POS = 15;
    localparam int A16_POS = 16;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_SEED = 8'h00;
    localparam logic [17:0] ADDR_USED_DEF = 18'h1_FFFF;
    localparam int FIFO_DEPTH_DEF = 8;

    typedef struct packed {
        logic act_n;
        logic [17:0] addr;
        logic [1:0] ba;
        logic [1:0] bg;
        logic par;
    } disp_cmd_s;

    typedef struct packed {
        logic [15:0] data;
        logic [1:0] keep;
    } disp_word_s;

    typedef struct packed {
        logic ck;
        logic cs_n;
        logic cke;
        logic termination_enable_in;
        disp_cmd_s cmd;
        logic [15:0] dq;
        logic [1:0] strb_t;
        logic [1:0] strb_c;
        logic [1:0] mask_n;
        logic connectivity_test_enable;
        logic alert;
    } disp_pin_s;

    typedef enum logic [2:0] {
        AL_IDLE = 3'b001,
        AL_CRC = 3'b010,
        AL_PAR = 3'b100
    } disp_alert_e;
endpackage
`default_nettype wire

// >>> verilog/disp_top.sv
// Integrity checks, strobed data lanes and error flag of the memory device.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module disp_fifo #(
    parameter int W = 18,
    parameter int DEPTH = 8
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [W-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [W-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_reg [DEPTH];
    logic [AW:0] wr_ptr_reg;
    logic [AW:0] rd_ptr_reg;
    logic full;
    logic empty;

    assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
    assign empty = wr_ptr_reg == rd_ptr_reg;
    assign in_ready_out = !full;
    assign out_valid_out = !empty;
    assign out_data_out = mem_reg[rd_ptr_reg[AW-1:0]];

    always_ff @(posedge clk_in) begin
        if (in_valid_in && !full) begin
            mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (in_valid_in && !full) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (out_ready_in && !empty) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end
endmodule // disp_fifo

////////////////////////////////////////////////////////////////////////////////
module disp_top #(
    parameter int LANES = 2,
    parameter logic [17:0] ADDR_USED = disp_pkg::ADDR_USED_DEF,
    parameter int FIFO_DEPTH = disp_pkg::FIFO_DEPTH_DEF
) (
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic CK_IN,
    input wire logic CS_N_IN,
    input wire logic CKE_IN,
    input wire logic TERMINATION_ENABLE_IN,
    input wire logic ROW_OPEN_CMD_N_IN,
    input wire logic [17:0] ADDR_IN,
    input wire logic [1:0] BANK_IN,
    input wire logic [1:0] GROUP_IN,
    input wire logic CMD_ADDR_PARITY_IN,
    input wire logic [15:0] DQ_IN,
    output logic [15:0] DQ_OUT,
    output logic [15:0] DQ_OE_OUT,
    input wire logic [1:0] BYTE_STROBE_T_IN,
    input wire logic [1:0] BYTE_STROBE_C_IN,
    output logic [1:0] BYTE_STROBE_T_OUT,
    output logic [1:0] BYTE_STROBE_C_OUT,
    output logic [1:0] BYTE_STROBE_OE_OUT,
    input wire logic [1:0] WRITE_BYTE_MASK_N_IN,
    output logic [1:0] BUS_INVERT_FLAG_N_OUT,
    output logic [1:0] BUS_INVERT_OE_OUT,
    output logic STROBE_TERM_OUT,
    output logic TERMINATION_STROBE_PAIR_TERM_OUT,
    input wire logic ALERT_IN,
    output logic ALERT_OUT,
    output logic ALERT_OE_OUT,
    output logic ALERT_TEST_OUT,
    input wire logic CONNECTIVITY_TEST_ENABLE_IN,
    output logic TEST_MODE_OUT,
    input wire logic MODE_REG_FIVE_PARITY_EN_IN,
    input wire logic [2:0] MODE_REG_FIVE_SHARED_PIN_IN,
    input wire logic MODE_CRC_EN_IN,
    input wire logic MODE_REG_FOUR_VREF_MON_IN,
    input wire logic MODE_REG_ONE_TERM_STROBE_IN,
    output logic VREF_MON_OUT,
    output logic PARITY_ERR_OUT,
    output logic CRC_ERR_OUT,
    output logic WR_VALID_OUT,
    output logic [15:0] WR_DATA_OUT,
    output logic [1:0] WR_KEEP_OUT,
    input wire logic WR_READY_IN,
    output logic WR_SPACE_OUT,
    input wire logic RD_VALID_IN,
    input wire logic [15:0] RD_DATA_IN,
    output logic RD_READY_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);

    function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [7:0] d);
        logic [7:0] c;
        c = crc;
        for (int i = 7; i >= 0; i--) begin
            c = c[7] ^ d[i] ? {c[6:0], 1'b0} ^ disp_pkg::CRC_POLY : {c[6:0], 1'b0};
        end
        return c;
    endfunction

    // Read inversion pays off when a byte has more zeros than ones.
    function automatic logic more_zeros(input logic [7:0] d);
        int ones;
        ones = 0;
        for (int i = 0; i < 8; i++) begin
            ones += int'(d[i]);
        end
        return ones < 4;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Every pin passes two flip-flops; only the second stage is ever read.
    disp_pkg::disp_pin_s pin_raw;
    disp_pkg::disp_pin_s meta_reg;
    disp_pkg::disp_pin_s pin_reg;

    assign pin_raw = '{ck: CK_IN, cs_n: CS_N_IN, cke: CKE_IN, termination_enable_in: TERMINATION_ENABLE_IN,
        cmd: '{act_n: ROW_OPEN_CMD_N_IN, addr: ADDR_IN, ba: BANK_IN, bg: GROUP_IN,
        par: CMD_ADDR_PARITY_IN}, dq: DQ_IN, strb_t: BYTE_STROBE_T_IN,
        strb_c: BYTE_STROBE_C_IN, mask_n: WRITE_BYTE_MASK_N_IN,
        connectivity_test_enable: CONNECTIVITY_TEST_ENABLE_IN, alert: ALERT_IN};

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            meta_reg <= '0;
            pin_reg <= '0;
        end else begin
            meta_reg <= pin_raw;
            pin_reg <= meta_reg;
        end
    end

    logic test_mode;
    assign test_mode = pin_reg.connectivity_test_enable;
    assign TEST_MODE_OUT = test_mode;

    ////////////////////////////////////////////////////////////////////////////
    // Command capture on rising edges of the command clock.
    logic ck_prev_reg;
    logic ck_rise;
    logic cmd_take;
    logic par_bad;
    logic par_check;
    logic is_write;
    logic par_err_reg;
    disp_pkg::disp_alert_e alert_state_reg;

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            ck_prev_reg <= 1'b0;
        end else begin
            ck_prev_reg <= pin_reg.ck;
        end
    end

    assign ck_rise = pin_reg.ck && !ck_prev_reg;
    assign cmd_take = ck_rise && !pin_reg.cs_n && !test_mode;
    // Chip select, clock enable and termination enable are left out here.
    assign par_bad = ^{pin_reg.cmd.act_n, pin_reg.cmd.addr & ADDR_USED,
        pin_reg.cmd.ba, pin_reg.cmd.bg, pin_reg.cmd.par};
    assign par_check = cmd_take && MODE_REG_FIVE_PARITY_EN_IN;
    assign is_write = cmd_take && pin_reg.cmd.act_n && pin_reg.cmd.addr[disp_pkg::A16_POS]
        && !pin_reg.cmd.addr[disp_pkg::A15_POS] && !pin_reg.cmd.addr[disp_pkg::A14_POS]
        && !(par_check && par_bad);

    ////////////////////////////////////////////////////////////////////////////
    // Shared pin function selection.
    logic term_strobe;
    logic mask_on;
    logic wdbi_on;
    logic rdbi_on;

    // The termination strobe exists on eight-bit parts only.
    assign term_strobe = MODE_REG_ONE_TERM_STROBE_IN && (LANES == 1);
    assign mask_on = !term_strobe && MODE_REG_FIVE_SHARED_PIN_IN[disp_pkg::SH_MASK_POS];
    assign wdbi_on = !term_strobe && !mask_on
        && MODE_REG_FIVE_SHARED_PIN_IN[disp_pkg::SH_WDBI_POS];
    assign rdbi_on = !term_strobe && MODE_REG_FIVE_SHARED_PIN_IN[disp_pkg::SH_RDBI_POS];

    ////////////////////////////////////////////////////////////////////////////
    // Write lanes: each byte is taken at an edge of its own strobe.
    logic [1:0] strb_prev_reg;
    logic [1:0] lane_edge;
    logic [1:0] lane_seen_reg;
    logic [1:0] lanes_mask;
    logic [15:0] beat_byte_reg;
    logic [1:0] beat_mask_reg;
    logic [15:0] beat_byte;
    logic [1:0] beat_mask;
    logic beat_done;

    assign lanes_mask = (LANES == 2) ? 2'b11 : 2'b01;

    always_comb begin
        for (int b = 0; b < 2; b++) begin
            // A pair whose halves agree is no valid differential level.
            lane_edge[b] = lanes_mask[b] && (pin_reg.strb_t[b] != pin_reg.strb_c[b])
                && (pin_reg.strb_t[b] != strb_prev_reg[b]);
        end
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            strb_prev_reg <= '0;
        end else begin
            for (int b = 0; b < 2; b++) begin
                if (pin_reg.strb_t[b] != pin_reg.strb_c[b]) begin
                    strb_prev_reg[b] <= pin_reg.strb_t[b];
                end
            end
        end
    end

    always_comb begin
        for (int b = 0; b < 2; b++) begin
            beat_byte[b*8 +: 8] = lane_edge[b] ? pin_reg.dq[b*8 +: 8]
                : beat_byte_reg[b*8 +: 8];
            beat_mask[b] = lane_edge[b] ? pin_reg.mask_n[b] : beat_mask_reg[b];
        end
    end

    assign beat_done = ((lane_seen_reg | lane_edge) == lanes_mask) && (lane_edge != 2'b00);

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            lane_seen_reg <= '0;
            beat_byte_reg <= '0;
            beat_mask_reg <= '0;
        end else begin
            lane_seen_reg <= beat_done ? 2'b00 : (lane_seen_reg | lane_edge);
            beat_byte_reg <= beat_byte;
            beat_mask_reg <= beat_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Burst tracking with the trailing CRC beat.
    logic [3:0] wr_left_reg;
    logic crc_due_reg;
    logic [15:0] crc_reg;
    logic data_beat;
    logic crc_beat;
    logic crc_err_reg;
    logic crc_mismatch;
    disp_pkg::disp_word_s push_word;

    assign data_beat = beat_done && (wr_left_reg != 4'h0);
    assign crc_beat = beat_done && (wr_left_reg == 4'h0) && crc_due_reg;
    assign crc_mismatch = (beat_byte[7:0] != crc_reg[7:0])
        || ((LANES == 2) && (beat_byte[15:8] != crc_reg[15:8]));

    always_comb begin
        for (int b = 0; b < 2; b++) begin
            push_word.data[b*8 +: 8] = (wdbi_on && !beat_mask[b]) ? ~beat_byte[b*8 +: 8]
                : beat_byte[b*8 +: 8];
            push_word.keep[b] = lanes_mask[b] && !(mask_on && !beat_mask[b]);
        end
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            wr_left_reg <= 4'h0;
            crc_due_reg <= 1'b0;
            crc_reg <= {2{disp_pkg::CRC_SEED}};
        end else if (is_write) begin
            wr_left_reg <= pin_reg.cmd.addr[disp_pkg::BURST_CHOP_BIT_POS] ? 4'(disp_pkg::BURST_BEATS)
                : 4'(disp_pkg::CHOP_BEATS);
            crc_due_reg <= MODE_CRC_EN_IN;
            crc_reg <= {2{disp_pkg::CRC_SEED}};
        end else if (data_beat) begin
            wr_left_reg <= wr_left_reg - 4'h1;
            // The check covers the bytes as they stood on the pins.
            crc_reg <= {crc8_step(crc_reg[15:8], beat_byte[15:8]),
                crc8_step(crc_reg[7:0], beat_byte[7:0])};
        end else if (crc_beat) begin
            crc_due_reg <= 1'b0;
        end
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            crc_err_reg <= 1'b0;
            par_err_reg <= 1'b0;
        end else begin
            crc_err_reg <= crc_beat && crc_mismatch;
            par_err_reg <= par_check && par_bad && (alert_state_reg != disp_pkg::AL_PAR);
        end
    end

    assign CRC_ERR_OUT = crc_err_reg;
    assign PARITY_ERR_OUT = par_err_reg;

    // Words arriving while the buffer is full are lost; the space flag warns the source.
    disp_fifo #(
        .W($bits(disp_pkg::disp_word_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_in(CLK_IN),
        .rst_in(RST_IN),
        .in_valid_in(data_beat),
        .in_ready_out(WR_SPACE_OUT),
        .in_data_in(push_word),
        .out_valid_out(WR_VALID_OUT),
        .out_ready_in(WR_READY_IN),
        .out_data_out({WR_DATA_OUT, WR_KEEP_OUT})
    );

    ////////////////////////////////////////////////////////////////////////////
    // Error flag: open drain, so the pin is only ever pulled low.
    logic [7:0] alert_cnt_reg;

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            alert_state_reg <= disp_pkg::AL_IDLE;
            alert_cnt_reg <= 8'h00;
        end else begin
            case (alert_state_reg)
                disp_pkg::AL_IDLE: begin
                    if (par_err_reg) begin
                        alert_state_reg <= disp_pkg::AL_PAR;
                        alert_cnt_reg <= 8'(disp_pkg::PAR_RECOV_CYC - 1);
                    end else if (crc_err_reg) begin
                        alert_state_reg <= disp_pkg::AL_CRC;
                        alert_cnt_reg <= 8'(disp_pkg::CRC_PULSE_CYC - 1);
                    end
                end
                disp_pkg::AL_CRC: begin
                    if (par_err_reg) begin
                        alert_state_reg <= disp_pkg::AL_PAR;
                        alert_cnt_reg <= 8'(disp_pkg::PAR_RECOV_CYC - 1);
                    end else if (alert_cnt_reg == 8'h00) begin
                        alert_state_reg <= disp_pkg::AL_IDLE;
                    end else begin
                        alert_cnt_reg <= alert_cnt_reg - 8'h01;
                    end
                end
                disp_pkg::AL_PAR: begin
                    if (alert_cnt_reg == 8'h00) begin
                        alert_state_reg <= disp_pkg::AL_IDLE;
                    end else begin
                        alert_cnt_reg <= alert_cnt_reg - 8'h01;
                    end
                end
                default: begin
                    alert_state_reg <= disp_pkg::AL_IDLE;
                end
            endcase
        end
    end

    assign ALERT_OUT = 1'b0;
    assign ALERT_OE_OUT = (alert_state_reg != disp_pkg::AL_IDLE) && !test_mode;
    assign ALERT_TEST_OUT = pin_reg.alert;

    ////////////////////////////////////////////////////////////////////////////
    // Read beats: data, flags and strobe change together, edge aligned.
    logic [7:0] rd_cnt_reg;
    logic rd_start;
    logic [15:0] dq_out_reg;
    logic [1:0] flag_n_reg;
    logic strb_t_reg;
    logic [15:0] dq_oe;

    assign RD_READY_OUT = (rd_cnt_reg == 8'h00) && !test_mode;
    assign rd_start = RD_VALID_IN && RD_READY_OUT;

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            rd_cnt_reg <= 8'h00;
            dq_out_reg <= '0;
            flag_n_reg <= 2'b11;
            strb_t_reg <= 1'b0;
        end else if (rd_start) begin
            rd_cnt_reg <= 8'(disp_pkg::RD_BEAT_CYC);
            strb_t_reg <= !strb_t_reg;
            for (int b = 0; b < 2; b++) begin
                flag_n_reg[b] <= !(rdbi_on && more_zeros(RD_DATA_IN[b*8 +: 8]));
                dq_out_reg[b*8 +: 8] <= (rdbi_on && more_zeros(RD_DATA_IN[b*8 +: 8]))
                    ? ~RD_DATA_IN[b*8 +: 8] : RD_DATA_IN[b*8 +: 8];
            end
        end else if (rd_cnt_reg != 8'h00) begin
            rd_cnt_reg <= rd_cnt_reg - 8'h01;
        end
    end

    // The monitored reference level owns the low data lines meanwhile.
    assign VREF_MON_OUT = MODE_REG_FOUR_VREF_MON_IN && !test_mode;
    assign dq_oe = (rd_cnt_reg != 8'h00) ? {{8{lanes_mask[1]}}, 8'hFF} : 16'h0000;
    assign DQ_OE_OUT = VREF_MON_OUT ? (dq_oe & 16'hFFF0) : dq_oe;
    assign DQ_OUT = dq_out_reg;
    assign BYTE_STROBE_T_OUT = {2{strb_t_reg}};
    assign BYTE_STROBE_C_OUT = {2{!strb_t_reg}};
    assign BYTE_STROBE_OE_OUT = (rd_cnt_reg != 8'h00) ? lanes_mask : 2'b00;
    assign BUS_INVERT_FLAG_N_OUT = flag_n_reg;
    assign BUS_INVERT_OE_OUT = (rd_cnt_reg != 8'h00 && rdbi_on) ? lanes_mask : 2'b00;
    assign STROBE_TERM_OUT = pin_reg.termination_enable_in && (rd_cnt_reg == 8'h00);
    assign TERMINATION_STROBE_PAIR_TERM_OUT = STROBE_TERM_OUT && term_strobe;

    ////////////////////////////////////////////////////////////////////////////
    chk_parity_flag: assert property (par_check && par_bad
        && alert_state_reg != disp_pkg::AL_PAR |=> PARITY_ERR_OUT)
        else $error("parity error not flagged");
    chk_parity_off: assert property (!MODE_REG_FIVE_PARITY_EN_IN
        && $past(!MODE_REG_FIVE_PARITY_EN_IN) |-> !PARITY_ERR_OUT)
        else $error("parity flagged while disabled");
    chk_cs_ignored: assert property (ck_rise && pin_reg.cs_n |=> !PARITY_ERR_OUT)
        else $error("deselected command checked");
    chk_crc_pulse: assert property (CRC_ERR_OUT && alert_state_reg == disp_pkg::AL_IDLE
        && !PARITY_ERR_OUT && !test_mode
        |=> (ALERT_OE_OUT || test_mode)[*6] ##1 (!ALERT_OE_OUT || alert_state_reg == disp_pkg::AL_PAR))
        else $error("crc alert pulse length wrong");
    chk_par_hold: assert property (PARITY_ERR_OUT && !test_mode ##1 !test_mode[*8]
        |-> ALERT_OE_OUT[*8])
        else $error("parity alert released early");
    chk_par_release: assert property (PARITY_ERR_OUT |-> ##[1:110]
        alert_state_reg == disp_pkg::AL_IDLE)
        else $error("parity recovery too long");
    chk_alert_input: assert property (test_mode |-> !ALERT_OE_OUT)
        else $error("error flag driven in test mode");
    chk_mask_drop: assert property (data_beat && mask_on && !beat_mask[0]
        |=> $past(!push_word.keep[0]))
        else $error("masked byte kept");
    chk_write_invert: assert property (data_beat && wdbi_on && !beat_mask[0]
        |-> push_word.data[7:0] == ~beat_byte[7:0])
        else $error("write inversion missing");
    chk_read_strobe: assert property (rd_start |=> BYTE_STROBE_OE_OUT[0]
        && BYTE_STROBE_T_OUT[0] != $past(BYTE_STROBE_T_OUT[0]) && DQ_OE_OUT[15:4] != 12'h000)
        else $error("read strobe not edge aligned");
endmodule // disp_top
`default_nettype wire

// >>> tb/disp_ctrl_model.sv
// Controller model driving the command clock, command words and write strobes.
`timescale 1ns/1ps
`default_nettype none
module disp_ctrl_model (
    output logic ck_out,
    output logic cs_n_out,
    output disp_pkg::disp_cmd_s cmd_out,
    output logic [15:0] dq_out,
    output logic [1:0] strb_out,
    output logic [1:0] mask_n_out
);
    initial begin
        ck_out = 1'b0;
        cs_n_out = 1'b1;
        cmd_out = '0;
        dq_out = 16'h0000;
        strb_out = 2'h0;
        mask_n_out = 2'h3;
    end
    // The command clock runs free, as a real controller keeps it.
    always #80 ck_out = ~ck_out;
    task automatic send(input logic sel_n, input disp_pkg::disp_cmd_s w);
        @(negedge ck_out);
        cs_n_out = sel_n;
        cmd_out = w;
        @(negedge ck_out);
        cs_n_out = 1'b1;
        cmd_out = ~w;
    endtask
    // Released data shows its inverse so a stale value cannot pass for a beat.
    task automatic beat(input logic [15:0] d, input logic [1:0] m);
        dq_out = d;
        mask_n_out = m;
        #40 strb_out = ~strb_out;
        #40 dq_out = ~d;
        #20;
    endtask
endmodule // disp_ctrl_model
`default_nettype wire

// >>> tb/tb_disp_top.sv
// Self-checking bench for the integrity, strobe and error flag pins.
`timescale 1ns/1ps
`default_nettype none
module tb_disp_top;
    logic clk = 1'b0, rst = 1'b1, rd_valid = 1'b0, wr_ready = 1'b0, connectivity_test_enable = 1'b0;
    logic alert_drv = 1'b1, par_en = 1'b0, vref = 1'b0, crc_en = 1'b0;
    logic [2:0] shared = 3'h0;
    logic [15:0] rd_data = 16'h0000;
    logic ck, cs_n, par_err, alert_oe, alert_t, test_m, vmon, wr_valid, wr_space, rd_ready;
    logic [15:0] dq, dq_o, dq_oe, wr_data;
    logic [1:0] strb, mask, st_t, st_c, st_oe, flag_n, wr_keep;
    disp_pkg::disp_cmd_s cmd, c;
    int cyc, par_cnt, oe_cnt, err_count, checked;
    initial forever #10 clk = ~clk;
    disp_ctrl_model u_ctrl (.ck_out(ck), .cs_n_out(cs_n), .cmd_out(cmd), .dq_out(dq),
        .strb_out(strb), .mask_n_out(mask));
    disp_top u_dut (.CLK_IN(clk), .RST_IN(rst), .CK_IN(ck), .CS_N_IN(cs_n), .CKE_IN(1'b1),
        .TERMINATION_ENABLE_IN(1'b0), .ROW_OPEN_CMD_N_IN(cmd.act_n), .ADDR_IN(cmd.addr),
        .BANK_IN(cmd.ba), .GROUP_IN(cmd.bg), .CMD_ADDR_PARITY_IN(cmd.par),
        .DQ_IN((dq_oe & dq_o) | (~dq_oe & dq)), .DQ_OUT(dq_o), .DQ_OE_OUT(dq_oe),
        .BYTE_STROBE_T_IN(strb), .BYTE_STROBE_C_IN(~strb), .BYTE_STROBE_T_OUT(st_t),
        .BYTE_STROBE_C_OUT(st_c), .BYTE_STROBE_OE_OUT(st_oe), .WRITE_BYTE_MASK_N_IN(mask),
        .BUS_INVERT_FLAG_N_OUT(flag_n), .BUS_INVERT_OE_OUT(), .STROBE_TERM_OUT(),
        .TERMINATION_STROBE_PAIR_TERM_OUT(), .ALERT_IN(alert_oe ? 1'b0 : alert_drv),
        .ALERT_OUT(), .ALERT_OE_OUT(alert_oe), .ALERT_TEST_OUT(alert_t),
        .CONNECTIVITY_TEST_ENABLE_IN(connectivity_test_enable), .TEST_MODE_OUT(test_m),
        .MODE_REG_FIVE_PARITY_EN_IN(par_en), .MODE_REG_FIVE_SHARED_PIN_IN(shared),
        .MODE_CRC_EN_IN(crc_en), .MODE_REG_FOUR_VREF_MON_IN(vref),
        .MODE_REG_ONE_TERM_STROBE_IN(1'b0), .VREF_MON_OUT(vmon), .PARITY_ERR_OUT(par_err),
        .CRC_ERR_OUT(), .WR_VALID_OUT(wr_valid), .WR_DATA_OUT(wr_data), .WR_KEEP_OUT(wr_keep),
        .WR_READY_IN(wr_ready), .WR_SPACE_OUT(wr_space), .RD_VALID_IN(rd_valid),
        .RD_DATA_IN(rd_data), .RD_READY_OUT(rd_ready));
    task automatic conclude();
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    always @(posedge clk) begin
        cyc++;
        par_cnt += (par_err === 1'b1);
        oe_cnt += (alert_oe === 1'b1);
        if (cyc == 20000) begin
            err_count++;
            conclude();
        end
    end
    function automatic logic bad_par(input disp_pkg::disp_cmd_s w);
        return ^{w.act_n, w.addr & disp_pkg::ADDR_USED_DEF, w.ba, w.bg, w.par};
    endfunction
    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
        for (int i = 7; i >= 0; i--) c = (c[7] ^ d[i]) ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
        return c;
    endfunction
    task automatic cmd_test(input logic sel_n, input disp_pkg::disp_cmd_s w);
        int p0 = par_cnt;
        int a0 = oe_cnt;
        logic e = !sel_n && !connectivity_test_enable && par_en && bad_par(w);
        u_ctrl.send(sel_n, w);
        repeat (120) @(posedge clk);
        check("par_err", 16'(par_cnt - p0), 16'(e));
        check("alert_cycles", 16'(oe_cnt - a0), e ? 16'h0064 : 16'h0000);
    endtask
    task automatic rd_test(input logic [15:0] d);
        logic [15:0] e;
        logic [1:0] f;
        logic [1:0] s = st_t;
        for (int b = 0; b < 2; b++) begin
            f[b] = !(shared[2] && $countones(d[8*b+:8]) < 4);
            e[8*b+:8] = f[b] ? d[8*b+:8] : ~d[8*b+:8];
        end
        rd_valid = 1'b1;
        rd_data = d;
        @(posedge clk);
        #1;
        rd_valid = 1'b0;
        check("rd_data", dq_o, e);
        check("rd_flag", 16'(flag_n), 16'(f));
        check("rd_oe", dq_oe, vref ? 16'hFFF0 : 16'hFFFF);
        check("vref_mon", 16'(vmon), 16'(vref));
        check("rd_strobe", 16'({st_t, st_c, st_oe}), 16'({~s, s, 2'h3}));
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic wr_test(input logic [2:0] mode);
        logic [15:0] d [8];
        logic [1:0] m [8];
        logic [15:0] e, k;
        logic [15:0] crc = 16'h0000;
        int n = 0;
        int a0 = oe_cnt;
        shared = mode;
        // A write command with an eight-beat burst.
        c = 24'hA2_0000;
        c.par = bad_par(c);
        u_ctrl.send(1'b0, c);
        for (int i = 0; i < 8; i++) begin
            d[i] = 16'($urandom);
            m[i] = 2'($urandom);
            u_ctrl.beat(d[i], m[i]);
            crc = {crc8(crc[15:8], d[i][15:8]), crc8(crc[7:0], d[i][7:0])};
        end
        // A corrupted trailing code must raise the short error pulse.
        if (crc_en) u_ctrl.beat(crc ^ 16'h0001, 2'h3);
        repeat (10) @(posedge clk);
        #1;
        check("fifo_space", 16'(wr_space), 16'h0000);
        wr_ready = 1'b1;
        for (int t = 0; t < 40 && n < 8; t++) begin
            if (wr_valid === 1'b1) begin
                k = mode[0] ? {{8{m[n][1]}}, {8{m[n][0]}}} : 16'hFFFF;
                e = mode[1] ? d[n] ^ ~{{8{m[n][1]}}, {8{m[n][0]}}} : d[n];
                check("wr_keep", 16'(wr_keep), 16'({k[8], k[0]}));
                check("wr_data", wr_data & k, e & k);
                n++;
            end
            @(posedge clk);
            #1;
        end
        wr_ready = 1'b0;
        check("crc_alert", 16'(oe_cnt - a0), crc_en ? 16'h0006 : 16'h0000);
        check("wr_count", 16'(n), 16'h0008);
        check("fifo_space", 16'(wr_space), 16'h0001);
    endtask
    initial begin
        void'($urandom(23346));
        repeat (5) @(posedge clk);
        #1;
        rst = 1'b0;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 24; i++) begin
            c = 24'($urandom);
            c.addr[16] = 1'b0;
            par_en = (i % 3 != 0);
            cmd_test(i[0], c);
        end
        $display("test parity done");
        connectivity_test_enable = 1'b1;
        alert_drv = 1'b0;
        repeat (5) @(posedge clk);
        check("test_mode", 16'(test_m), 16'h0001);
        check("alert_in", 16'(alert_t), 16'h0000);
        cmd_test(1'b0, 24'h00_0001);
        connectivity_test_enable = 1'b0;
        alert_drv = 1'b1;
        repeat (5) @(posedge clk);
        check("test_mode", 16'(test_m), 16'h0000);
        $display("test connectivity done");
        for (int i = 0; i < 8; i++) begin
            shared = 3'($urandom);
            vref = i[0];
            rd_test(16'($urandom));
        end
        shared = 3'h4;
        rd_test(16'h0F07);
        $display("test read done");
        vref = 1'b0;
        par_en = 1'b1;
        wr_test(3'h1);
        crc_en = 1'b1;
        wr_test(3'h2);
        $display("test write done");
        conclude();
    end
endmodule // tb_disp_top
`default_nettype wire
